// [tb/testbench.sv]
/*
  testbench for the command and status register block
  assumes design inputs driven at the falling edge
*/
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [6:0] ev = 7'h00;
  logic ofs, occ, brun, crun, busy, susp, hold, rhr, run, seen;
  int failures = 0;
  int cmp_count = 0;
  int ovf = 0;
  int n, b;
  localparam int SR_CYC = 2;
  always #50 core_clk = ~core_clk;
  always @(negedge core_clk) if (ofs === 1'b1) ovf++;
  ucs_host_model u_host (.core_clk(core_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  ucs_command_status #(.RESET_CYC(SR_CYC)) u_dut (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sched_overrun(ev[0]), .frame_num_updated(ev[1]),
    .ownership_done(ev[2]), .bulk_head_check(ev[3]),
    .bulk_td_found(ev[4]), .ctrl_head_check(ev[5]),
    .ctrl_td_found(ev[6]), .overrun_flag_set(ofs),
    .ownership_changed_flag(occ), .bulk_run(brun), .ctrl_run(crun),
    .soft_reset_busy(busy), .suspend_enter(susp),
    .host_bus_hold(hold), .root_hub_reset(rhr));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic pulse(input logic [6:0] m);
    @(negedge core_clk);
    ev = m;
    @(negedge core_clk);
    ev = 7'h00;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1_000_000;
    failures++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    u_host.rd(8'h08, rv);
    check(rv, ucs_pkg::CMD_STATUS_RESET);
    u_host.wr(8'h0C, 32'h0000_0004);
    u_host.wr(8'h08, 32'h0000_0002);
    u_host.wr(8'h08, 32'h0000_0000);
    u_host.rd(8'h08, rv);
    check(rv, 32'h0000_0002);
    u_host.wr(8'h08, 32'h0000_0004);
    u_host.rd(8'h08, rv);
    check(rv, 32'h0000_0006);
    for (int i = 0; i < 2; i++) begin
      b = i ? ucs_pkg::CTRL_FILLED_BIT : ucs_pkg::BULK_FILLED_BIT;
      pulse(i ? 7'h20 : 7'h08);
      run = i ? crun : brun;
      check({31'b0, run}, 32'h1);
      u_host.rd(8'h08, rv);
      check({31'b0, rv[b]}, 32'h0);
      pulse(i ? 7'h40 : 7'h10);
      u_host.rd(8'h08, rv);
      check({31'b0, rv[b]}, 32'h1);
      pulse(i ? 7'h20 : 7'h08);
      pulse(i ? 7'h20 : 7'h08);
      run = i ? crun : brun;
      check({31'b0, run}, 32'h0);
      fork
        u_host.wr(8'h08, 32'h1 << b);
        pulse(i ? 7'h20 : 7'h08);
      join
      u_host.rd(8'h08, rv);
      check({31'b0, rv[b]}, 32'h1);
    end
    u_host.wr(8'h08, 32'h0000_0008);
    check({31'b0, occ}, 32'h1);
    pulse(7'h04);
    check({31'b0, occ}, 32'h0);
    u_host.rd(8'h08, rv);
    check(rv, 32'h0000_0006);
    for (int k = 1; k <= 5; k++) begin
      pulse(7'h03);
      u_host.rd(8'h08, rv);
      check({30'b0, rv[17:16]}, k % 4);
    end
    check(ovf, 5);
    pulse(7'h01);
    u_host.rd(8'h08, rv);
    check({30'b0, rv[17:16]}, 32'h2);
    check(ovf, 5);
    pulse(7'h02);
    u_host.rd(8'h08, rv);
    check(ovf, 6);
    u_host.wr(8'h08, 32'h0000_0001);
    seen = 1'b0;
    for (n = 0; n < 200; n++) begin
      @(negedge core_clk);
      if (busy === 1'b1) seen = 1'b1;
      check({31'b0, hold}, {31'b0, n < SR_CYC});
      check({31'b0, busy}, {31'b0, n < SR_CYC});
      check({31'b0, rhr}, 32'h0);
      if (susp === 1'b1) break;
    end
    check({31'b0, n <= ucs_pkg::RESET_MAX_CYC}, 32'h1);
    check(n, SR_CYC);
    check({31'b0, seen & susp}, 32'h1);
    u_host.rd(8'h08, rv);
    check(rv, 32'h0000_0000);
    summarize();
  end
endmodule

// [tb/ucs_host_model.sv]
/*
  host driver model: single-word register reads and writes
  assumes strobes sampled on the rising edge of core_clk
*/
`timescale 1ns/1ps
module ucs_host_model (
  input  wire logic        core_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
  end
  // unused ranges always written as zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d & 32'h0000_000F;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge core_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask
endmodule

// [verilog/ucs_command_status.sv]
/*
  command and status register with write-to-set commands
  assumes list engines, frame timer and event register are outside
*/
`timescale 1ns/1ps
module ucs_command_status #(
  parameter int RESET_CYC = ucs_pkg::RESET_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        sched_overrun,
  input  wire logic        frame_num_updated,
  input  wire logic        ownership_done,
  input  wire logic        bulk_head_check,
  input  wire logic        bulk_td_found,
  input  wire logic        ctrl_head_check,
  input  wire logic        ctrl_td_found,
  output logic             overrun_flag_set,
  output logic             ownership_changed_flag,
  output logic             bulk_run,
  output logic             ctrl_run,
  output logic             soft_reset_busy,
  output logic             suspend_enter,
  output logic             host_bus_hold,
  output logic             root_hub_reset
);
  typedef enum logic [1:0] {UCS_IDLE, UCS_RESET, UCS_DONE} ucs_rst_e;

  logic     soft_reset_cmd, next_soft_reset_cmd;
  logic     control_list_filled, next_control_list_filled;
  logic     bulk_list_filled, next_bulk_list_filled;
  logic     ownership_request, next_ownership_request;
  logic [1:0] ovr_cnt, next_ovr_cnt;
  logic     ovr_pend, next_ovr_pend;
  ucs_rst_e rst_st, next_rst_st;
  logic [15:0] rst_cnt, next_rst_cnt;
  logic [31:0] next_reg_rdata;
  logic     next_bulk_run, next_ctrl_run;
  logic     next_overrun_flag_set, next_suspend_enter;
  logic     wr_hit;
  logic [31:0] cur;

  function automatic logic [31:0] pack_reg(
    input logic [1:0] cnt, input logic oreq, input logic bf,
    input logic cf, input logic sr);
    logic [31:0] v;
    v = ucs_pkg::CMD_STATUS_RESET;
    v[ucs_pkg::OVR_CNT_HI:ucs_pkg::OVR_CNT_LO] = cnt;
    v[ucs_pkg::OWN_REQ_BIT] = oreq;
    v[ucs_pkg::BULK_FILLED_BIT] = bf;
    v[ucs_pkg::CTRL_FILLED_BIT] = cf;
    v[ucs_pkg::SOFT_RESET_BIT] = sr;
    return v;
  endfunction

  assign wr_hit = reg_wr && reg_addr == ucs_pkg::CMD_STATUS_OFFSET;
  assign cur = pack_reg(ovr_cnt, ownership_request, bulk_list_filled,
                        control_list_filled, soft_reset_cmd);
  assign ownership_changed_flag = ownership_request;
  assign soft_reset_busy = rst_st == UCS_RESET;
  assign host_bus_hold = rst_st == UCS_RESET;
  assign root_hub_reset = 1'b0;

  always_comb begin
    next_soft_reset_cmd = soft_reset_cmd;
    next_control_list_filled = control_list_filled;
    next_bulk_list_filled = bulk_list_filled;
    next_ownership_request = ownership_request;
    next_ovr_cnt = ovr_cnt;
    next_ovr_pend = ovr_pend;
    next_overrun_flag_set = 1'b0;
    next_bulk_run = bulk_run;
    next_ctrl_run = ctrl_run;
    next_reg_rdata = reg_rdata;
    if (reg_rd && reg_addr == ucs_pkg::CMD_STATUS_OFFSET) begin
      next_reg_rdata = cur;
    end else if (reg_rd) begin
      next_reg_rdata = ucs_pkg::CMD_STATUS_RESET;
    end
    if (sched_overrun) begin
      next_ovr_cnt = ovr_cnt + 2'h1;
      next_ovr_pend = 1'b1;
    end
    if ((ovr_pend || sched_overrun) && frame_num_updated) begin
      next_overrun_flag_set = 1'b1;
      next_ovr_pend = 1'b0;
    end
    if (ownership_done) begin
      next_ownership_request = 1'b0;
    end
    if (bulk_head_check) begin
      next_bulk_run = bulk_list_filled;
      next_bulk_list_filled = 1'b0;
    end
    if (bulk_td_found) begin
      next_bulk_list_filled = 1'b1;
    end
    if (ctrl_head_check) begin
      next_ctrl_run = control_list_filled;
      next_control_list_filled = 1'b0;
    end
    if (ctrl_td_found) begin
      next_control_list_filled = 1'b1;
    end
    if (rst_st == UCS_DONE) begin
      next_soft_reset_cmd = 1'b0;
      next_control_list_filled = 1'b0;
      next_bulk_list_filled = 1'b0;
      next_ownership_request = 1'b0;
      next_ovr_cnt = 2'h0;
      next_ovr_pend = 1'b0;
      next_bulk_run = 1'b0;
      next_ctrl_run = 1'b0;
    end
    if (wr_hit) begin
      // set-only writes, applied last so a set wins a clear
      if (reg_wdata[ucs_pkg::SOFT_RESET_BIT]) begin
        next_soft_reset_cmd = 1'b1;
      end
      if (reg_wdata[ucs_pkg::CTRL_FILLED_BIT]) begin
        next_control_list_filled = 1'b1;
      end
      if (reg_wdata[ucs_pkg::BULK_FILLED_BIT]) begin
        next_bulk_list_filled = 1'b1;
      end
      if (reg_wdata[ucs_pkg::OWN_REQ_BIT]) begin
        next_ownership_request = 1'b1;
      end
    end
  end

  always_comb begin
    next_rst_st = rst_st;
    next_rst_cnt = rst_cnt;
    next_suspend_enter = 1'b0;
    unique case (rst_st)
      UCS_IDLE: begin
        if (soft_reset_cmd) begin
          next_rst_st = UCS_RESET;
          next_rst_cnt = 16'h0000;
        end
      end
      UCS_RESET: begin
        next_rst_cnt = rst_cnt + 16'h0001;
        if (rst_cnt == 16'(RESET_CYC - 1)) begin
          next_rst_st = UCS_DONE;
          next_suspend_enter = 1'b1;
        end
      end
      UCS_DONE: begin
        next_rst_st = UCS_IDLE;
      end
      default: next_rst_st = UCS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_reset_cmd <= 1'b0;
      control_list_filled <= 1'b0;
      bulk_list_filled <= 1'b0;
      ownership_request <= 1'b0;
      ovr_cnt <= 2'h0;
      ovr_pend <= 1'b0;
      overrun_flag_set <= 1'b0;
      bulk_run <= 1'b0;
      ctrl_run <= 1'b0;
      reg_rdata <= ucs_pkg::CMD_STATUS_RESET;
      rst_st <= UCS_IDLE;
      rst_cnt <= 16'h0000;
      suspend_enter <= 1'b0;
    end else begin
      soft_reset_cmd <= next_soft_reset_cmd;
      control_list_filled <= next_control_list_filled;
      bulk_list_filled <= next_bulk_list_filled;
      ownership_request <= next_ownership_request;
      ovr_cnt <= next_ovr_cnt;
      ovr_pend <= next_ovr_pend;
      overrun_flag_set <= next_overrun_flag_set;
      bulk_run <= next_bulk_run;
      ctrl_run <= next_ctrl_run;
      reg_rdata <= next_reg_rdata;
      rst_st <= next_rst_st;
      rst_cnt <= next_rst_cnt;
      suspend_enter <= next_suspend_enter;
    end
  end

  int unsigned rst_age;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_age <= 0;
    end else if (soft_reset_cmd && rst_st != UCS_DONE) begin
      rst_age <= rst_age + 1;
    end else begin
      rst_age <= 0;
    end
  end

  localparam int SR_LIMIT = ucs_pkg::RESET_MAX_CYC;

  sequence sr_start_s;
    soft_reset_cmd && rst_st == UCS_IDLE;
  endsequence

  sequence sr_finish_s;
    soft_reset_busy ##[0:SR_LIMIT] suspend_enter;
  endsequence

  write_sets_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_hit && reg_wdata[ucs_pkg::OWN_REQ_BIT] && !ownership_done
    |=> ownership_request)
    else $error("ownership request not set by write");
  zero_keeps_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_hit && !reg_wdata[ucs_pkg::OWN_REQ_BIT] && !ownership_done
    && rst_st != UCS_DONE |=> $stable(ownership_request))
    else $error("zero write changed ownership request");
  read_value_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == ucs_pkg::CMD_STATUS_OFFSET
    |=> reg_rdata == $past(cur))
    else $error("read data does not match register");
  ovr_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sched_overrun && rst_st != UCS_DONE
    |=> ovr_cnt == $past(ovr_cnt) + 2'h1)
    else $error("overrun count did not advance");
  ovr_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sched_overrun && frame_num_updated |=> overrun_flag_set)
    else $error("overrun flag not raised");
  own_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_hit && reg_wdata[ucs_pkg::OWN_REQ_BIT] |=> ownership_changed_flag)
    else $error("ownership changed flag missing");
  own_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ownership_done && !(wr_hit && reg_wdata[ucs_pkg::OWN_REQ_BIT])
    |=> !ownership_request)
    else $error("ownership request not cleared");
  bulk_head_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bulk_head_check && !bulk_td_found && !wr_hit && rst_st != UCS_DONE
    |=> !bulk_list_filled && bulk_run == $past(bulk_list_filled))
    else $error("bulk head check wrong");
  bulk_td_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bulk_td_found && rst_st != UCS_DONE |=> bulk_list_filled)
    else $error("bulk filled not set on descriptor");
  ctrl_head_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ctrl_head_check && !ctrl_td_found && !wr_hit && rst_st != UCS_DONE
    |=> !control_list_filled && ctrl_run == $past(control_list_filled))
    else $error("control head check wrong");
  ctrl_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_hit && reg_wdata[ucs_pkg::CTRL_FILLED_BIT] |=> control_list_filled)
    else $error("software set lost to device clear");
  reset_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rst_age <= ucs_pkg::RESET_MAX_CYC)
    else $error("soft reset took too long");
  reset_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sr_start_s |=> host_bus_hold && !root_hub_reset)
    else $error("bus not held or hub reset");
  reset_finish_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    sr_start_s |=> sr_finish_s)
    else $error("soft reset did not reach suspend");
endmodule

// [verilog/ucs_pkg.sv]
/*
  constants for the command and status register block
  assumes a 32-bit register access port and a 10 MHz core clock
*/
package ucs_pkg;
  localparam logic [7:0]  CMD_STATUS_OFFSET = 8'h08;
  localparam logic [31:0] CMD_STATUS_RESET  = 32'h0000_0000;
  localparam int          SOFT_RESET_BIT    = 0;
  localparam int          CTRL_FILLED_BIT   = 1;
  localparam int          BULK_FILLED_BIT   = 2;
  localparam int          OWN_REQ_BIT       = 3;
  localparam int          OVR_CNT_LO        = 16;
  localparam int          OVR_CNT_HI        = 17;
  localparam logic [1:0]  FS_BUS_RESET      = 2'h0;
  localparam logic [1:0]  FS_RESUMING       = 2'h1;
  localparam logic [1:0]  FS_RUNNING        = 2'h2;
  localparam logic [1:0]  FS_SUSPENDED      = 2'h3;
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          RESET_MAX_US      = 10;
  localparam int          RESET_MAX_CYC     =
    (RESET_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int          RESET_CYC         = 16;
endpackage
